/* File: common/write_crc_defs.svh */
// Timing counts, burst layout and checksum constants for the write checksum checker
`ifndef WRITE_CRC_DEFS_SVH
`define WRITE_CRC_DEFS_SVH

// ----------------------------------------------------------------------------
// Burst layout
// ----------------------------------------------------------------------------
`define BURST_BEATS 10
`define DATA_BEATS 8
`define CRC_BEAT_LO 4'h8
`define CRC_BEAT_HI 4'h9
`define LAST_BEAT 4'h9
`define CODE_BITS 72
`define MASK_BIT_BASE 64

// ----------------------------------------------------------------------------
// Checksum
// ----------------------------------------------------------------------------
`define CRC_POLY 8'h07
`define CRC_INIT 8'h00

// ----------------------------------------------------------------------------
// Alert pulse timing
// ----------------------------------------------------------------------------
`define CORE_PERIOD_NS 10
`define ALERT_NS 60
`define ALERT_CYCLES ((`ALERT_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)

`endif

/* File: common/write_crc_pkg.sv */
// Types shared by the write checksum checker
`default_nettype none
package write_crc_pkg;
  typedef enum logic [1:0] {WIDTH_X4, WIDTH_X8, WIDTH_X16} width_e;

  typedef struct packed {
    width_e width;
    logic crc_en;
    logic mask_en;
    logic dbi_en;
  } cfg_s;

  // One transfer as seen on the pins: 16 data lanes, two active-low mask/inversion pins
  typedef struct packed {
    logic [15:0] dq;
    logic [1:0] dmi_n;
  } beat_s;

  typedef struct packed {
    beat_s [9:0] beat;
  } burst_s;

  // Byte (beat b, group g) sits at data[(b*2+g)*8 +: 8], enable at byte_en[b*2+g]
  typedef struct packed {
    logic [127:0] data;
    logic [15:0] byte_en;
  } array_word_s;

  typedef struct packed {
    logic [3:0] beat_cnt;
    logic in_burst;
    burst_s collect;
    burst_s hold;
    logic tog;
  } link_state_s;

  typedef struct packed {
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    logic pend;
    burst_s word;
    logic overrun;
    logic [7:0] alert_cnt;
    logic alert_n;
    logic crc_error;
    logic discard;
    logic done;
    array_word_s out;
    logic out_v;
    array_word_s skid;
    logic skid_v;
  } core_state_s;
endpackage
`default_nettype wire

/* File: design/write_crc_checker.sv */
// Write checksum checker: burst capture on the link clock, check and commit on the core clock
// Function
// (RQ1) Four-bit device: 32 data bits, upper 40 ones
// (RQ2) Eight-bit device: 64 data, 8 mask-or-ones bits
// (RQ3) Sixteen-bit device: two identical checksum trees
// (RQ4) Controller drives ones in transfer nine
// (RQ5) Mismatch of recomputed checksum raises alert
// (RQ6) Without masking, data commits regardless of check
// (RQ7) Controller rewrites location after reported error
// (RQ8) Masking plus checksum: bad burst is discarded
// (RQ9) Checksum taken over data before inversion undo
// (RQ10) Inverted bytes restored before storing
// (RQ11) No register or per-device writes meanwhile
// (RQ12) Generator polynomial x8 plus x2 plus x plus 1
// (RQ13) Bit 71 enters the shift first
// (RQ14) Checksum starts from zero each word
// (RQ15) Checksum may be pure combinational logic
// (RQ16) Detects single, double, odd and column errors
// (RQ17) Upper checksum byte guards upper 72 bits
// (RQ18) Checksum bits ride transfer eight per lane
// (RQ19) Each burst judged alone, alert only on mismatch
`default_nettype none
`include "write_crc_defs.svh"

module write_crc_checker
  import write_crc_pkg::*;
#(
  parameter int unsigned ALERT_LEN = `ALERT_CYCLES
) (
  input wire logic core_clk_in,              // Core clock, 100 MHz
  input wire logic rst_n_in,                 // Asynchronous reset, active low
  input wire logic link_clk_in,              // Write data strobe clock
  input wire logic link_beat_valid_in,       // A transfer is on the pins this edge
  input wire logic link_first_in,            // Marks transfer 0 of a burst
  input wire beat_s link_beat_in,            // Data lanes and mask/inversion pins
  input wire cfg_s cfg_in,                   // Width and feature enables
  input wire logic array_ready_in,           // Array accepts a word
  output logic array_valid_out,              // Word offered to the array
  output array_word_s array_word_out,        // Restored data with byte enables
  output logic alert_n_out,                  // Checksum alert, active low
  output logic crc_error_out,                // One-cycle pulse per failing burst
  output logic discard_out,                  // One-cycle pulse: burst dropped
  output logic burst_done_out,               // One-cycle pulse: burst judged
  output logic overrun_out                   // One-cycle pulse: burst lost waiting
);

  // The alert counter is eight bits wide and must load a non-zero length
  if (ALERT_LEN < 1 || ALERT_LEN > 255) begin : g_alert_len_check
    $error("ALERT_LEN out of range");
  end

  // --------------------------------------------------------------------------
  // Checksum and code word helpers
  // --------------------------------------------------------------------------
  // Serial form unrolls into the same xor trees as the parallel equations
  function automatic logic [7:0] crc8(input logic [71:0] d);
    logic [7:0] c;
    logic fb;
    c = `CRC_INIT; // RQ14
    for (int i = `CODE_BITS - 1; i >= 0; i--) begin // RQ13 RQ15
      fb = c[7] ^ d[i];
      c = {c[6:0], 1'b0};
      if (fb) begin
        c = c ^ `CRC_POLY; // RQ12
      end
    end
    return c;
  endfunction

  // Raw pins feed the tree; inversion is never undone here
  function automatic logic [71:0] code_word(input burst_s b, input int g, input width_e w,
                                            input logic pin_used);
    logic [71:0] d;
    d = '1; // RQ1
    for (int bt = 0; bt < `DATA_BEATS; bt++) begin
      for (int n = 0; n < 8; n++) begin
        if (w != WIDTH_X4 || n < 4) begin
          d[n * 8 + bt] = b.beat[bt].dq[g * 8 + n]; // RQ9
        end
      end
      if (w != WIDTH_X4 && pin_used) begin
        d[`MASK_BIT_BASE + bt] = b.beat[bt].dmi_n[g]; // RQ2
      end
    end
    return d;
  endfunction

  function automatic logic [7:0] rx_crc(input burst_s b, input int g, input width_e w);
    logic [7:0] c;
    c = '0;
    for (int n = 0; n < 8; n++) begin
      if (w == WIDTH_X4) begin
        c[n] = (n < 4) ? b.beat[`CRC_BEAT_LO].dq[n] : b.beat[`CRC_BEAT_HI].dq[n - 4];
      end else begin
        c[n] = b.beat[`CRC_BEAT_LO].dq[g * 8 + n]; // RQ18
      end
    end
    return c;
  endfunction

  // --------------------------------------------------------------------------
  // Link domain: gather ten transfers, hand the burst over by a toggle
  // --------------------------------------------------------------------------
  // The held burst stays still for a whole following burst (ten link edges),
  // far longer than the three core edges the toggle needs to cross.
  link_state_s link_q;
  link_state_s link_d;

  always_comb begin
    link_d = link_q;
    if (link_beat_valid_in) begin
      if (link_first_in) begin
        link_d.collect.beat[0] = link_beat_in;
        link_d.beat_cnt = 4'h1;
        link_d.in_burst = 1'b1;
      end else if (link_q.in_burst) begin
        link_d.collect.beat[link_q.beat_cnt] = link_beat_in;
        link_d.beat_cnt = link_q.beat_cnt + 4'h1;
        if (link_q.beat_cnt == `LAST_BEAT) begin
          link_d.hold = link_d.collect;
          link_d.tog = ~link_q.tog;
          link_d.in_burst = 1'b0;
          link_d.beat_cnt = 4'h0;
        end
      end
    end
  end

  always_ff @(posedge link_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link_q <= '0;
    end else begin
      link_q <= link_d;
    end
  end

  // --------------------------------------------------------------------------
  // Core domain: check, restore, buffer
  // --------------------------------------------------------------------------
  core_state_s core_q;
  core_state_s core_d;
  logic new_burst_w;
  logic eval_w;
  logic pin_used_w;
  logic lo_bad_w;
  logic hi_bad_w;
  logic err_w;
  logic commit_w;
  logic pop_w;
  array_word_s word_w;

  assign new_burst_w = core_q.tog_s2 ^ core_q.tog_s3;
  // A burst is judged when one is pending and the skid slot is free
  assign eval_w = core_q.pend && !core_q.skid_v;
  assign pin_used_w = cfg_in.mask_en | cfg_in.dbi_en;
  assign lo_bad_w = crc8(code_word(core_q.word, 0, cfg_in.width, pin_used_w))
                    != rx_crc(core_q.word, 0, cfg_in.width); // RQ5
  assign hi_bad_w = crc8(code_word(core_q.word, 1, cfg_in.width, pin_used_w))
                    != rx_crc(core_q.word, 1, cfg_in.width); // RQ17
  assign err_w = cfg_in.crc_en && (lo_bad_w || (cfg_in.width == WIDTH_X16 && hi_bad_w)); // RQ3
  assign commit_w = !(cfg_in.crc_en && cfg_in.mask_en && err_w); // RQ6 RQ8
  assign pop_w = core_q.out_v && array_ready_in;

  always_comb begin
    logic [7:0] byte_v;
    logic pin;
    byte_v = '0;
    pin = 1'b0;
    word_w = '0;
    for (int bt = 0; bt < `DATA_BEATS; bt++) begin
      for (int g = 0; g < 2; g++) begin
        byte_v = core_q.word.beat[bt].dq[g * 8 +: 8];
        pin = core_q.word.beat[bt].dmi_n[g];
        if (cfg_in.dbi_en && !cfg_in.mask_en && !pin) begin
          byte_v = ~byte_v; // RQ10
        end
        if (cfg_in.width == WIDTH_X4) begin
          byte_v[7:4] = 4'h0;
        end
        word_w.data[(bt * 2 + g) * 8 +: 8] = byte_v;
        word_w.byte_en[bt * 2 + g] = !(cfg_in.mask_en && !pin)
                                     && (g == 0 || cfg_in.width == WIDTH_X16);
      end
    end
  end

  always_comb begin
    core_d = core_q;
    core_d.tog_s1 = link_q.tog;
    core_d.tog_s2 = core_q.tog_s1;
    core_d.tog_s3 = core_q.tog_s2;
    core_d.overrun = 1'b0;
    core_d.crc_error = 1'b0;
    core_d.discard = 1'b0;
    core_d.done = 1'b0;
    // Array side drains first so a push in the same cycle lands in the freed slot
    if (pop_w) begin
      if (core_q.skid_v) begin
        core_d.out = core_q.skid;
        core_d.skid_v = 1'b0;
      end else begin
        core_d.out_v = 1'b0;
      end
    end
    if (eval_w) begin // RQ19
      core_d.pend = 1'b0;
      core_d.done = 1'b1;
      core_d.crc_error = err_w;
      core_d.discard = !commit_w; // RQ8
      if (commit_w) begin
        if (!core_d.out_v) begin
          core_d.out = word_w;
          core_d.out_v = 1'b1;
        end else begin
          core_d.skid = word_w;
          core_d.skid_v = 1'b1;
        end
      end
    end
    if (err_w && eval_w) begin
      core_d.alert_cnt = 8'(ALERT_LEN); // RQ5
    end else if (core_q.alert_cnt != 8'h00) begin
      core_d.alert_cnt = core_q.alert_cnt - 8'h01;
    end
    core_d.alert_n = !((err_w && eval_w) || core_q.alert_cnt > 8'h01);
    // A burst still waiting when the next arrives is replaced; that loss is flagged
    if (new_burst_w) begin
      core_d.overrun = core_q.pend && !eval_w;
      core_d.word = link_q.hold;
      core_d.pend = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      core_q <= '0;
      core_q.alert_n <= 1'b1;
    end else begin
      core_q <= core_d;
    end
  end

  assign array_valid_out = core_q.out_v;
  assign array_word_out = core_q.out;
  assign alert_n_out = core_q.alert_n;
  assign crc_error_out = core_q.crc_error;
  assign discard_out = core_q.discard;
  assign burst_done_out = core_q.done;
  assign overrun_out = core_q.overrun;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_judged_bad;
    burst_done_out && crc_error_out;
  endsequence

  sequence s_eval_commit;
    eval_w && commit_w;
  endsequence

  property p_alert_len;
    s_judged_bad |-> (!alert_n_out)[*6];
  endproperty
  a_alert_len: assert property (p_alert_len) else $error("alert shorter than pulse"); // RQ5

  property p_alert_cause;
    $fell(alert_n_out) |-> crc_error_out && $past(cfg_in.crc_en);
  endproperty
  a_alert_cause: assert property (p_alert_cause) else $error("alert without error"); // RQ19

  property p_discard;
    discard_out |-> crc_error_out && $past(cfg_in.mask_en) && $past(cfg_in.crc_en);
  endproperty
  a_discard: assert property (p_discard) else $error("discard without masked error"); // RQ8

  property p_commit;
    s_eval_commit |=> burst_done_out && !discard_out && array_valid_out;
  endproperty
  a_commit: assert property (p_commit) else $error("committed burst not offered"); // RQ6

  property p_poly;
    1'b1 |-> crc8(72'h1) == 8'h07 && crc8({1'b1, 71'h0}) == 8'h34;
  endproperty
  a_poly: assert property (p_poly) else $error("checksum polynomial or order wrong"); // RQ12 RQ13

  property p_zero;
    1'b1 |-> crc8(72'h0) == 8'h00;
  endproperty
  a_zero: assert property (p_zero) else $error("checksum seed not zero"); // RQ14

  property p_upper;
    eval_w && cfg_in.crc_en && cfg_in.width == WIDTH_X16 && hi_bad_w |=> crc_error_out;
  endproperty
  a_upper: assert property (p_upper) else $error("upper tree mismatch missed"); // RQ17

  property p_invert;
    eval_w && cfg_in.dbi_en && !cfg_in.mask_en && !core_q.word.beat[0].dmi_n[0]
      && cfg_in.width != WIDTH_X4 && !core_q.out_v
      |=> array_word_out.data[7:0] == ~$past(core_q.word.beat[0].dq[7:0]);
  endproperty
  a_invert: assert property (p_invert) else $error("inverted byte not restored"); // RQ10

  property p_no_loss;
    array_valid_out && !array_ready_in |=> array_valid_out && $stable(array_word_out);
  endproperty
  a_no_loss: assert property (p_no_loss) else $error("stalled word changed or lost");

  property p_single_bit;
    eval_w |-> crc8(code_word(core_q.word, 0, cfg_in.width, pin_used_w) ^ 72'h1)
               != crc8(code_word(core_q.word, 0, cfg_in.width, pin_used_w));
  endproperty
  a_single_bit: assert property (p_single_bit) else $error("single bit flip undetected"); // RQ16

endmodule
`default_nettype wire

/* File: verif/crc_ctrl_model.sv */
// Controller model: builds checksummed write bursts and drives them on the link
`default_nettype none
module crc_ctrl_model
  import write_crc_pkg::*;
(
  output logic link_clk_out, // Strobe, toggles only during a burst and its idle lead edge
  output logic valid_out,    // Transfer present
  output logic first_out,    // Transfer 0 marker
  output beat_s beat_out     // Lanes and mask/inversion pins
);
  timeunit 1ns;
  timeprecision 10ps;

  initial begin
    link_clk_out = 1'b0;
    valid_out = 1'b0;
    first_out = 1'b0;
    beat_out = '1;
  end

  function automatic logic [7:0] crc72(input logic [71:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 71; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction

  // -------------------------------------------------------------------------
  // Only data bursts are issued while the checksum is on
  // -------------------------------------------------------------------------
  task automatic send(input width_e w, input logic pins, input logic [127:0] dat,
                      input logic [15:0] dmi, input logic [15:0] flip);
    logic [71:0] cw;
    logic [15:0] crc;
    beat_s b [10];
    for (int g = 0; g < 2; g++) begin
      cw = '1;
      for (int t = 0; t < 8; t++) begin
        for (int n = 0; n < 8; n++) begin
          if (w != WIDTH_X4 || n < 4) cw[n*8+t] = dat[t*16+g*8+n];
        end
        if (pins && w != WIDTH_X4) cw[64+t] = dmi[t*2+g];
      end
      crc[g*8+:8] = crc72(cw) ^ flip[g*8+:8];
    end
    for (int t = 0; t < 8; t++) b[t] = {dat[t*16+:16], (pins ? dmi[t*2+:2] : 2'b11)};
    b[8] = {crc, 2'b11};
    b[9] = {16'hffff, 2'b11};
    if (w == WIDTH_X4) begin
      b[8] = {12'hfff, crc[3:0], 2'b11};
      b[9] = {12'hfff, crc[7:4], 2'b11};
    end
    // One idle edge leads each burst, like a write preamble
    for (int t = -1; t < 10; t++) begin
      valid_out = (t >= 0);
      first_out = (t == 0);
      beat_out = (t >= 0) ? b[t] : ~b[0];
      #3.75 link_clk_out = 1'b1;
      #7.5 link_clk_out = 1'b0;
      #3.75;
    end
    valid_out = 1'b0;
    first_out = 1'b0;
    // Released lines must not keep showing the last transfer
    beat_out = ~b[9];
  endtask
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the write checksum checker
`default_nettype none
module testbench
  import write_crc_pkg::*;
;
  timeunit 1ns;
  timeprecision 10ps;
  localparam logic [127:0] PAT = 128'h0123456789abcdef_fedcba9876543210;
  logic core_clk_in, rst_n_in, link_clk, valid, first, ready, a_valid;
  logic alert_n, crc_err, disc, done, ovr;
  beat_s beat;
  cfg_s cfg;
  array_word_s word;
  int miscompares = 0;
  int n_compared = 0;

  write_crc_checker write_crc_checker_inst (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk),
    .link_beat_valid_in(valid), .link_first_in(first), .link_beat_in(beat),
    .cfg_in(cfg), .array_ready_in(ready), .array_valid_out(a_valid),
    .array_word_out(word), .alert_n_out(alert_n), .crc_error_out(crc_err),
    .discard_out(disc), .burst_done_out(done), .overrun_out(ovr));
  crc_ctrl_model crc_ctrl_model_inst (
    .link_clk_out(link_clk), .valid_out(valid), .first_out(first), .beat_out(beat));

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  task automatic check(input string what, input logic [143:0] seen, input logic [143:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wait_done();
    int k;
    k = 0;
    do begin
      @(negedge core_clk_in);
      k++;
      if (k > 50) begin
        miscompares++;
        print_verdict();
      end
    end while (done !== 1'b1);
  endtask

  // -------------------------------------------------------------------------
  // One burst, checked in the core cycle its done pulse appears
  // -------------------------------------------------------------------------
  task automatic xfer(input width_e w, input logic m, input logic d, input logic [127:0] dat,
      input logic [15:0] dmi, input logic [15:0] flip, input logic [127:0] exp,
      input logic [15:0] en, input logic bad);
    logic [127:0] msk;
    for (int i = 0; i < 16; i++) msk[i*8+:8] = {8{en[i]}};
    cfg = '{w, 1'b1, m, d};
    crc_ctrl_model_inst.send(w, m | d, dat, dmi, flip);
    wait_done();
    check("crc_error", crc_err, bad);
    check("discard", disc, bad & m);
    check("alert_n", alert_n, !bad);
    check("array_valid", a_valid, !(bad & m));
    check("overrun", ovr, 1'b0);
    if (!(bad & m)) begin
      check("data", word.data & msk, exp & msk);
      check("byte_en", word.byte_en, en);
    end
    if (bad) begin
      repeat (5) @(negedge core_clk_in);
      check("alert_hold", alert_n, 1'b0);
      @(negedge core_clk_in);
      check("alert_end", alert_n, 1'b1);
    end
  endtask

  task automatic scen_errors();
    logic [7:0] f [3] = '{8'h01, 8'h81, 8'h07};
    for (int i = 0; i < 3; i++) xfer(WIDTH_X8, 0, 0, PAT, '1, {8'h00, f[i]}, PAT, 16'h5555, 1);
    xfer(WIDTH_X8, 0, 0, ~PAT, '1, '0, ~PAT, 16'h5555, 0);
  endtask

  task automatic scen_mask();
    xfer(WIDTH_X8, 1, 0, PAT, 16'hfffb, '0, PAT, 16'h5551, 0);
    xfer(WIDTH_X8, 1, 0, PAT, 16'hfffb, 16'h0004, PAT, 16'h5551, 1);
  endtask

  task automatic scen_dbi();
    xfer(WIDTH_X8, 0, 1, PAT, 16'hffbe, '0, PAT ^ 128'h00ff_0000_0000_00ff, 16'h5555, 0);
  endtask

  task automatic scen_x16_x4();
    xfer(WIDTH_X16, 0, 0, PAT, '1, '0, PAT, 16'hffff, 0);
    xfer(WIDTH_X16, 0, 0, PAT, '1, 16'h0100, PAT, 16'hffff, 1);
    xfer(WIDTH_X4, 0, 0, PAT, '1, '0, PAT & {8{16'h000f}}, 16'h5555, 0);
    xfer(WIDTH_X4, 0, 0, PAT, '1, 16'h0010, PAT & {8{16'h000f}}, 16'h5555, 1);
  endtask

  // Both buffer slots fill while the array stalls; nothing may be lost
  task automatic scen_stall();
    ready = 1'b0;
    cfg = '{WIDTH_X8, 1'b1, 1'b0, 1'b0};
    crc_ctrl_model_inst.send(WIDTH_X8, 1'b0, PAT, '1, '0);
    wait_done();
    crc_ctrl_model_inst.send(WIDTH_X8, 1'b0, ~PAT, '1, '0);
    wait_done();
    check("stall_valid", a_valid, 1'b1);
    check("stall_first", word.data & {8{16'h00ff}}, PAT & {8{16'h00ff}});
    ready = 1'b1;
    @(negedge core_clk_in);
    check("stall_second", word.data & {8{16'h00ff}}, ~PAT & {8{16'h00ff}});
    @(negedge core_clk_in);
    check("drained", a_valid, 1'b0);
  endtask

  // Out and skid slots full, a third burst waits; the fourth replaces it
  task automatic scen_overrun();
    int k;
    ready = 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(negedge core_clk_in);
      crc_ctrl_model_inst.send(WIDTH_X8, 1'b0, PAT, '1, '0);
    end
    k = 0;
    while (ovr !== 1'b1 && k < 20) begin
      @(negedge core_clk_in);
      k++;
    end
    check("overrun", ovr, 1'b1);
    @(negedge core_clk_in);
    ready = 1'b1;
    repeat (4) @(negedge core_clk_in);
    check("overrun_drained", a_valid, 1'b0);
  endtask

  initial begin
    rst_n_in = 1'b0;
    ready = 1'b1;
    cfg = '{WIDTH_X8, 1'b1, 1'b0, 1'b0};
    repeat (4) @(negedge core_clk_in);
    check("reset_valid", a_valid, 1'b0);
    check("reset_alert", alert_n, 1'b1);
    rst_n_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    xfer(WIDTH_X8, 0, 0, PAT, '1, '0, PAT, 16'h5555, 0);
    scen_errors();
    scen_mask();
    scen_dbi();
    scen_x16_x4();
    scen_stall();
    scen_overrun();
    print_verdict();
  end
endmodule
`default_nettype wire
